// ==== common/lmc_pkg.sv ====
package lmc_pkg;
  // frame layout
  localparam int unsigned DATA_MAX = 8;
  localparam logic [5:0] ID_MASTER_REQ = 6'h3C;
  localparam logic [7:0] SLEEP_FIRST = 8'h00;
  localparam logic [7:0] SLEEP_FILL = 8'hFF;
  localparam logic [7:0] CS_GOOD = 8'hFF;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_MID = 4'h4;
  localparam logic [3:0] LEN_LONG = 4'h8;
  localparam logic [3:0] IDX_CLOSED = 4'hF;
  localparam logic [1:0] ID_SHORT_GOTO4 = 2'h3;
  // command codes and motion constants
  localparam logic [6:0] CMD_DECEL_STOP = 7'h0F;
  localparam logic [6:0] CMD_EMF_PROBE = 7'h1F;
  localparam logic [10:0] SEC_POS_NONE = 11'h400;
  localparam logic [1:0] STEP_HALF = 2'h0;
  // controller register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DATA_LO = 4'h4;
  localparam logic [3:0] ADDR_DATA_HI = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam int unsigned CTRL_ID_LSB = 0;
  localparam int unsigned CTRL_START_BIT = 8;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // identifier with its two parity bits on top
  function automatic logic [7:0] protect_id(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction: protect_id

  // data byte count carried by an identifier
  function automatic logic [3:0] data_len(input logic [5:0] id);
    return id[5] ? (id[4] ? LEN_LONG : LEN_MID) : LEN_SHORT;
  endfunction: data_len

  // sum with end-around carry
  function automatic logic [7:0] cs_add(input logic [7:0] acc, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction: cs_add
endpackage: lmc_pkg

// ==== common/lmc_link_if.sv ====
interface lmc_link_if;
  logic byte_valid;
  logic frame_start;
  logic [7:0] frame_byte;

  modport master (
    output byte_valid,
    output frame_start,
    output frame_byte
  );

  modport node (
    input byte_valid,
    input frame_start,
    input frame_byte
  );
endinterface: lmc_link_if

// ==== hdl/lmc_node_end.sv ====
// Local design decisions: the AXI4-Lite register port and the address map.
module lmc_node_end (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // frame link
  lmc_link_if.node link,
  // node configuration
  input wire logic [6:0] phys_addr,
  input wire logic [1:0] step_resolution,
  input wire logic sleep_permit,
  input wire logic [5:0] goto_param_id,
  input wire logic [10:0] secondary_position,
  // motion state
  input wire logic [15:0] actual_position,
  input wire logic motor_moving,
  input wire logic two_target_run,
  input wire logic thermal_shutdown,
  input wire logic emf_integrator,
  // switch pin
  input wire logic switch_pin_in,
  output logic switch_pin_out,
  output logic switch_pin_oe_n,
  output logic switch_state,
  // motion commands
  output logic [15:0] target_position,
  output logic [3:0] top_speed_code,
  output logic [3:0] min_speed_code,
  output logic [3:0] stall_threshold_code,
  output logic [3:0] accel_code,
  output logic goto_start,
  output logic decel_stop,
  output logic sleep_state,
  output logic stopped_state,
  output logic emf_probe_active
);
  logic [3:0] idx_q;
  logic [5:0] id_q;
  logic id_ok_q;
  logic [7:0] sum_q;
  logic frame_ok_q;
  logic [7:0] data_q [lmc_pkg::DATA_MAX];
  logic [3:0] len;
  logic [15:0] target_q;
  logic [3:0] top_q;
  logic [3:0] min_q;
  logic [3:0] thr_q;
  logic [3:0] acc_q;
  logic start_q;
  logic decel_q;
  logic pend_q;
  logic sleep_q;
  logic stopped_q;
  logic emf_q;
  logic pin_out_q;
  logic pin_oe_n_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic switch_q;
  logic therm_prev_q;

  assign len = lmc_pkg::data_len(id_q);

  // frame reception
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q <= lmc_pkg::IDX_CLOSED;
      id_q <= 6'h00;
      id_ok_q <= 1'b0;
      sum_q <= 8'h00;
      frame_ok_q <= 1'b0;
    end
    else
    begin
      frame_ok_q <= 1'b0;
      if (link.byte_valid)
      begin
        if (link.frame_start)
        begin
          id_q <= link.frame_byte[5:0];
          id_ok_q <= link.frame_byte == lmc_pkg::protect_id(link.frame_byte[5:0]);
          idx_q <= 4'h0;
          sum_q <= 8'h00;
        end
        else if (idx_q < len)
        begin
          sum_q <= lmc_pkg::cs_add(sum_q, link.frame_byte);
          idx_q <= idx_q + 4'h1;
        end
        else if (idx_q == len)
        begin
          frame_ok_q <= id_ok_q && lmc_pkg::cs_add(sum_q, link.frame_byte) == lmc_pkg::CS_GOOD;
          idx_q <= lmc_pkg::IDX_CLOSED;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (link.byte_valid && !link.frame_start && idx_q < len)
    begin
      data_q[idx_q[2:0]] <= link.frame_byte;
    end
  end

  // command decode
  logic [3:0] slot_hit;
  logic [10:0] slot_pos [4];
  logic short_ok;
  logic [10:0] short_pos;
  logic fill_ok;
  logic sleep_hit;
  logic cmd_frame;
  logic addressed;
  logic stop_hit;
  logic emf_hit;
  logic param_hit;
  logic stop_req;

  for (genvar k = 0; k < 4; k++)
  begin : g_slot
    assign slot_hit[k] = data_q[2*k][4] && data_q[2*k][3:0] == phys_addr[3:0];
    assign slot_pos[k] = {data_q[2*k][7:5], data_q[2*k+1]};
  end

  always_comb
  begin
    short_ok = 1'b0;
    short_pos = 11'h000;
    for (int k = 3; k >= 0; k--)
    begin
      if (slot_hit[k])
      begin
        short_ok = 1'b1;
        short_pos = slot_pos[k];
      end
    end
    fill_ok = 1'b1;
    for (int k = 1; k < lmc_pkg::DATA_MAX; k++)
    begin
      if (data_q[k] != lmc_pkg::SLEEP_FILL)
      begin
        fill_ok = 1'b0;
      end
    end
  end

  assign sleep_hit = frame_ok_q && id_q == lmc_pkg::ID_MASTER_REQ
    && data_q[0] == lmc_pkg::SLEEP_FIRST && fill_ok;
  assign cmd_frame = frame_ok_q && len == lmc_pkg::LEN_SHORT && data_q[0][7];
  assign addressed = !data_q[1][7] || data_q[1][6:0] == phys_addr;
  assign stop_hit = cmd_frame && data_q[0][6:0] == lmc_pkg::CMD_DECEL_STOP && addressed;
  assign emf_hit = cmd_frame && data_q[0][6:0] == lmc_pkg::CMD_EMF_PROBE && addressed;
  assign param_hit = frame_ok_q && id_q == goto_param_id && len == lmc_pkg::LEN_MID;
  assign stop_req = (stop_hit || (thermal_shutdown && !therm_prev_q)) && !two_target_run;

  logic short_hit;
  assign short_hit = frame_ok_q && id_q[5:4] == lmc_pkg::ID_SHORT_GOTO4
    && id_q != lmc_pkg::ID_MASTER_REQ && step_resolution == lmc_pkg::STEP_HALF
    && short_ok;

  logic sleep_moving;
  logic sec_valid;
  assign sleep_moving = sleep_hit && motor_moving;
  assign sec_valid = secondary_position != lmc_pkg::SEC_POS_NONE;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      therm_prev_q <= 1'b0;
    end
    else
    begin
      therm_prev_q <= thermal_shutdown;
    end
  end

  // target position
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      target_q <= 16'h0000;
    end
    else if (decel_q && !motor_moving)
    begin
      target_q <= actual_position;
    end
    else if (sleep_moving && sec_valid)
    begin
      target_q <= {{5{secondary_position[10]}}, secondary_position};
    end
    else if (param_hit)
    begin
      target_q <= {data_q[0], data_q[1]};
    end
    else if (short_hit)
    begin
      target_q <= {{5{short_pos[10]}}, short_pos};
    end
  end

  // motion parameters and start pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      top_q <= 4'h0;
      min_q <= 4'h0;
      thr_q <= 4'h0;
      acc_q <= 4'h0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= param_hit || short_hit;
      if (param_hit)
      begin
        top_q <= data_q[2][7:4];
        min_q <= data_q[2][3:0];
        thr_q <= data_q[3][7:4];
        acc_q <= data_q[3][3:0];
      end
    end
  end

  // decelerating stop: ramp to min speed, then hold
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decel_q <= 1'b0;
    end
    else if (decel_q && !motor_moving)
    begin
      decel_q <= 1'b0;
    end
    else if (motor_moving && (stop_req || (sleep_moving && !sec_valid)))
    begin
      decel_q <= 1'b1;
    end
  end

  // sleep decision once motion has ended
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_q <= 1'b0;
      sleep_q <= 1'b0;
      stopped_q <= 1'b0;
    end
    else if (sleep_hit)
    begin
      pend_q <= 1'b1;
    end
    else if (pend_q && !motor_moving && !decel_q)
    begin
      pend_q <= 1'b0;
      sleep_q <= sleep_permit;
      stopped_q <= !sleep_permit;
    end
    else if (start_q)
    begin
      sleep_q <= 1'b0;
      stopped_q <= 1'b0;
    end
  end

  // integrator probe mode, sticky until reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      emf_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else
    begin
      emf_q <= emf_q || emf_hit;
      pin_out_q <= emf_q && emf_integrator;
      pin_oe_n_q <= !emf_q;
    end
  end

  // switch input sampling
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      switch_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= switch_pin_in;
      pin_s2_q <= pin_s1_q;
      if (!emf_q)
      begin
        switch_q <= pin_s2_q;
      end
    end
  end

  assign target_position = target_q;
  assign top_speed_code = top_q;
  assign min_speed_code = min_q;
  assign stall_threshold_code = thr_q;
  assign accel_code = acc_q;
  assign goto_start = start_q;
  assign decel_stop = decel_q;
  assign sleep_state = sleep_q;
  assign stopped_state = stopped_q;
  assign emf_probe_active = emf_q;
  assign switch_pin_out = pin_out_q;
  assign switch_pin_oe_n = pin_oe_n_q;
  assign switch_state = switch_q;
endmodule: lmc_node_end

// ==== hdl/lmc_master_end.sv ====
module lmc_master_end (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // frame link
  lmc_link_if.master link
);
  logic aw_free_q;
  logic w_free_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [5:0] id_q;
  logic [31:0] lo_q;
  logic [31:0] hi_q;
  logic busy_q;
  logic [3:0] pos_q;
  logic [7:0] sum_q;
  logic tx_valid_q;
  logic tx_start_q;
  logic [7:0] tx_byte_q;
  logic do_write;
  logic known_w;
  logic go;
  logic [63:0] payload;
  logic [7:0] next_byte;

  assign do_write = !aw_free_q && !w_free_q && !bvalid_q;
  assign known_w = awaddr_q == lmc_pkg::ADDR_CTRL || awaddr_q == lmc_pkg::ADDR_DATA_LO
    || awaddr_q == lmc_pkg::ADDR_DATA_HI || awaddr_q == lmc_pkg::ADDR_STATUS;
  assign go = do_write && awaddr_q == lmc_pkg::ADDR_CTRL && wstrb_q[1]
    && wdata_q[lmc_pkg::CTRL_START_BIT] && !busy_q;

  // write channels
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_free_q <= 1'b1;
      w_free_q <= 1'b1;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= lmc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && aw_free_q)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_free_q <= 1'b0;
      end
      if (s_axi_wvalid && w_free_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_free_q <= 1'b0;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= known_w ? lmc_pkg::RESP_OKAY : lmc_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_free_q <= 1'b1;
        w_free_q <= 1'b1;
      end
    end
  end

  // own registers; the identifier is software's per-motor choice
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      id_q <= 6'h00;
      lo_q <= 32'h00000000;
      hi_q <= 32'h00000000;
    end
    else if (do_write)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wstrb_q[b] && awaddr_q == lmc_pkg::ADDR_DATA_LO)
        begin
          lo_q[8*b +: 8] <= wdata_q[8*b +: 8];
        end
        if (wstrb_q[b] && awaddr_q == lmc_pkg::ADDR_DATA_HI)
        begin
          hi_q[8*b +: 8] <= wdata_q[8*b +: 8];
        end
      end
      if (awaddr_q == lmc_pkg::ADDR_CTRL && wstrb_q[0] && !busy_q)
      begin
        id_q <= wdata_q[lmc_pkg::CTRL_ID_LSB +: 6];
      end
    end
  end

  // read channel
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= lmc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= lmc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        lmc_pkg::ADDR_CTRL: rdata_q <= {26'h0000000, id_q};
        lmc_pkg::ADDR_DATA_LO: rdata_q <= lo_q;
        lmc_pkg::ADDR_DATA_HI: rdata_q <= hi_q;
        lmc_pkg::ADDR_STATUS: rdata_q <= {31'h00000000, busy_q};
        default:
        begin
          rdata_q <= 32'h00000000;
          rresp_q <= lmc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // frame sender: protected id, data bytes, checksum, one per cycle
  assign payload = {hi_q, lo_q};
  assign next_byte = payload[{pos_q[2:0] - 3'h1, 3'h0} +: 8];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      pos_q <= 4'h0;
      sum_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_start_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end
    else if (go)
    begin
      busy_q <= 1'b1;
      pos_q <= 4'h1;
      sum_q <= 8'h00;
      tx_valid_q <= 1'b1;
      tx_start_q <= 1'b1;
      tx_byte_q <= lmc_pkg::protect_id(wdata_q[lmc_pkg::CTRL_ID_LSB +: 6]);
    end
    else if (busy_q && pos_q <= lmc_pkg::data_len(id_q))
    begin
      tx_start_q <= 1'b0;
      tx_byte_q <= next_byte;
      sum_q <= lmc_pkg::cs_add(sum_q, next_byte);
      pos_q <= pos_q + 4'h1;
    end
    else if (busy_q && tx_valid_q)
    begin
      tx_byte_q <= ~sum_q;
      tx_valid_q <= 1'b1;
      busy_q <= 1'b0;
    end
    else
    begin
      tx_valid_q <= 1'b0;
      tx_start_q <= 1'b0;
    end
  end

  assign s_axi_awready = aw_free_q;
  assign s_axi_wready = w_free_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link.byte_valid = tx_valid_q;
  assign link.frame_start = tx_start_q;
  assign link.frame_byte = tx_byte_q;
endmodule: lmc_master_end

// ==== verif/lmc_link_chk.sv ====
module lmc_link_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // frame link
  input wire logic byte_valid,
  input wire logic frame_start,
  input wire logic [7:0] frame_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rem_q;
  logic [7:0] sum_q;
  logic [8:0] add;
  logic par0;
  logic par1;
  assign add = {1'b0, sum_q} + {1'b0, frame_byte};
  assign par0 = frame_byte[0] ^ frame_byte[1] ^ frame_byte[2] ^ frame_byte[4];
  assign par1 = ~(frame_byte[1] ^ frame_byte[3] ^ frame_byte[4] ^ frame_byte[5]);
  // bytes still owed by the open frame, checksum included
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rem_q <= 4'h0;
    else if (byte_valid && frame_start)
      rem_q <= frame_byte[5] ? (frame_byte[4] ? 4'h9 : 4'h5) : 4'h3;
    else if (byte_valid && rem_q != 4'h0)
      rem_q <= rem_q - 4'h1;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sum_q <= 8'h00;
    else if (byte_valid && frame_start)
      sum_q <= 8'h00;
    else if (byte_valid)
      sum_q <= add[7:0] + {7'h00, add[8]};
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_head;
    byte_valid && frame_start;
  endsequence
  sequence s_data1;
    byte_valid && !frame_start;
  endsequence
  property p_start_valid;
    frame_start |-> byte_valid;
  endproperty
  a_start_valid: assert property (p_start_valid)
    else $error("identifier without byte strobe");
  property p_id_parity;
    s_head |-> frame_byte[7:6] == {par1, par0};
  endproperty
  a_id_parity: assert property (p_id_parity)
    else $error("identifier parity wrong");
  property p_len_long;
    s_head ##0 (frame_byte[5:4] == 2'h3) |=> s_data1 [*8] ##1 s_data1;
  endproperty
  a_len_long: assert property (p_len_long)
    else $error("eight byte frame malformed");
  property p_len_mid;
    s_head ##0 (frame_byte[5:4] == 2'h2) |=> s_data1 [*4] ##1 s_data1;
  endproperty
  a_len_mid: assert property (p_len_mid)
    else $error("four byte frame malformed");
  property p_len_short;
    s_head ##0 !frame_byte[5] |=> s_data1 [*2] ##1 s_data1;
  endproperty
  a_len_short: assert property (p_len_short)
    else $error("two byte frame malformed");
  property p_no_stray;
    s_data1 |-> rem_q != 4'h0;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("byte outside a frame");
  property p_no_overlap;
    frame_start |-> rem_q == 4'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("frame started inside a frame");
  property p_checksum;
    s_data1 ##0 (rem_q == 4'h1) |-> frame_byte == ~sum_q;
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("checksum byte wrong");
endmodule: lmc_link_chk

// ==== verif/lin_motor_command_decoder_tb.sv ====
module lin_motor_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0] id;
    logic [63:0] d;
    logic [15:0] tgt;
    logic [15:0] codes;
    logic [1:0] pulses;
  } lmc_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_b;
  logic [6:0] phys_addr = 7'h15;
  logic [1:0] step_resolution = 2'h0;
  logic [5:0] goto_param_id = 6'h21;
  logic [10:0] secondary_position = 11'h123;
  logic [15:0] actual_position = 16'h0, target_position, b_target;
  logic sleep_permit = 1'b0, motor_moving = 1'b0, two_target_run = 1'b0;
  logic thermal_shutdown = 1'b0, emf_integrator = 1'b0, switch_pin_in = 1'b0;
  logic switch_pin_out, switch_pin_oe_n, switch_state, goto_start, decel_stop;
  logic sleep_state, stopped_state, emf_probe_active;
  logic [3:0] top_speed_code, min_speed_code, stall_threshold_code, accel_code;
  logic [31:0] rd;
  logic [1:0] rr;
  int n_errors = 0, checks = 0, n_goto = 0, g;
  lmc_row_t rows [5] = '{
    '{6'h21, 64'h8001A3C700000000, 16'h8001, 16'hA3C7, 2'h1},
    '{6'h22, 64'h1111222200000000, 16'h8001, 16'hA3C7, 2'h0},
    '{6'h30, 64'h3311B5AB15221600, 16'hFDAB, 16'hA3C7, 2'h1},
    '{6'h31, 64'h0510051005100510, 16'hFDAB, 16'hA3C7, 2'h0},
    '{6'h32, 64'h1600170036007521, 16'h0321, 16'hA3C7, 2'h1}};
  lmc_link_if lk ();
  lmc_link_if lk2 ();
  lmc_master_end u_lmc_master_end (.link(lk), .*);
  lmc_node_end u_lmc_node_end (.link(lk), .*);
  lmc_node_end u_lmc_node_end_b (.clock, .rst_n, .link(lk2), .phys_addr, .step_resolution,
    .sleep_permit, .goto_param_id, .secondary_position, .actual_position, .motor_moving,
    .two_target_run, .thermal_shutdown, .emf_integrator, .switch_pin_in,
    .switch_pin_out(), .switch_pin_oe_n(),
    .switch_state(), .target_position(b_target), .top_speed_code(), .min_speed_code(),
    .stall_threshold_code(), .accel_code(), .goto_start(), .decel_stop(), .sleep_state(),
    .stopped_state(), .emf_probe_active());
  lmc_link_chk u_lmc_link_chk (.clock, .rst_n, .byte_valid(lk.byte_valid),
    .frame_start(lk.frame_start), .frame_byte(lk.frame_byte));
  always #5 clock = ~clock;
  always @(posedge clock)
    if (goto_start === 1'b1) n_goto++;
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask: chk
  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask: test_done
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_b = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask: axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask: axr
  // load data words, start the frame, poll until sent, let the node act
  task automatic send(input logic [5:0] id, input logic [63:0] d);
    axw(lmc_pkg::ADDR_DATA_LO, {d[39:32], d[47:40], d[55:48], d[63:56]});
    axw(lmc_pkg::ADDR_DATA_HI, {d[7:0], d[15:8], d[23:16], d[31:24]});
    axw(lmc_pkg::ADDR_CTRL, {23'h000000, 1'b1, 2'h0, id});
    do
    begin
      axr(lmc_pkg::ADDR_STATUS, rd, rr);
    end while (rd[0] !== 1'b0);
    repeat (4) @(posedge clock);
  endtask: send
  // hand-built four byte frame on the second link
  task automatic raw(input logic [7:0] pid, input logic [31:0] d, input logic [7:0] cs);
    lk2.byte_valid <= 1'b1;
    lk2.frame_start <= 1'b1;
    lk2.frame_byte <= pid;
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clock);
      lk2.frame_start <= 1'b0;
      lk2.frame_byte <= (k < 4) ? d[31 - 8 * k -: 8] : cs;
    end
    @(posedge clock);
    lk2.byte_valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask: raw
  initial
  begin
    #200000;
    n_errors++;
    test_done();
  end
  initial
  begin
    lk2.byte_valid = 1'b0;
    lk2.frame_start = 1'b0;
    lk2.frame_byte = 8'h00;
    repeat (9) @(posedge clock);
    chk("reset target", target_position, 16'h0000);
    chk("reset oe", switch_pin_oe_n, 16'h0001);
    chk("reset awready", s_axi_awready, 16'h0001);
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i])
    begin
      g = n_goto;
      send(rows[i].id, rows[i].d);
      chk("target", target_position, rows[i].tgt);
      chk("codes", {top_speed_code, min_speed_code, stall_threshold_code, accel_code},
        rows[i].codes);
      chk("pulses", 16'(n_goto - g), 16'(rows[i].pulses));
    end
    step_resolution <= 2'h1;
    send(6'h30, 64'h3311B5AB15221600);
    chk("other step mode", target_position, 16'h0321);
    step_resolution <= 2'h0;
    motor_moving <= 1'b1;
    send(6'h05, {16'h8F96, 48'h0});
    chk("stop other node", decel_stop, 16'h0000);
    send(6'h05, {16'h8F06, 48'h0});
    chk("stop broadcast", decel_stop, 16'h0001);
    actual_position <= 16'h1234;
    motor_moving <= 1'b0;
    repeat (4) @(posedge clock);
    chk("stop hold", target_position, 16'h1234);
    chk("stop end", decel_stop, 16'h0000);
    motor_moving <= 1'b1;
    two_target_run <= 1'b1;
    send(6'h0A, {16'h8F95, 48'h0});
    chk("stop in dual run", decel_stop, 16'h0000);
    two_target_run <= 1'b0;
    send(6'h0A, {16'h8F95, 48'h0});
    chk("stop addressed", decel_stop, 16'h0001);
    motor_moving <= 1'b0;
    repeat (4) @(posedge clock);
    motor_moving <= 1'b1;
    thermal_shutdown <= 1'b1;
    repeat (4) @(posedge clock);
    chk("thermal stop", decel_stop, 16'h0001);
    motor_moving <= 1'b0;
    thermal_shutdown <= 1'b0;
    send(6'h3C, 64'h00FFFFFFFFFFFFFF);
    chk("no permit", stopped_state, 16'h0001);
    chk("no permit sleep", sleep_state, 16'h0000);
    sleep_permit <= 1'b1;
    send(6'h3C, 64'h00FFFFFFFFFFFFFF);
    chk("sleep", sleep_state, 16'h0001);
    send(6'h21, 64'h8001A3C700000000);
    motor_moving <= 1'b1;
    send(6'h3C, 64'h00FFFFFFFFFFFFFF);
    chk("sleep secondary", target_position, 16'h0123);
    secondary_position <= lmc_pkg::SEC_POS_NONE;
    send(6'h21, 64'h8001A3C700000000);
    send(6'h3C, 64'h00FFFFFFFFFFFFFF);
    chk("sleep decel", decel_stop, 16'h0001);
    motor_moving <= 1'b0;
    switch_pin_in <= 1'b1;
    repeat (4) @(posedge clock);
    chk("switch sampled", switch_state, 16'h0001);
    send(6'h05, {16'h9F83, 48'h0});
    chk("probe other node", emf_probe_active, 16'h0000);
    send(6'h05, {16'h9F07, 48'h0});
    chk("probe broadcast", emf_probe_active, 16'h0001);
    chk("probe drives pin", switch_pin_oe_n, 16'h0000);
    emf_integrator <= 1'b1;
    switch_pin_in <= 1'b0;
    repeat (4) @(posedge clock);
    chk("probe high", switch_pin_out, 16'h0001);
    chk("switch frozen", switch_state, 16'h0001);
    emf_integrator <= 1'b0;
    send(6'h05, {16'h8F95, 48'h0});
    chk("probe low", switch_pin_out, 16'h0000);
    chk("probe sticky", emf_probe_active, 16'h0001);
    axr(lmc_pkg::ADDR_DATA_LO, rd, rr);
    chk("data lo", rd[15:0], 16'h958F);
    axr(4'h6, rd, rr);
    chk("bad read", {rr, rd[13:0]}, {lmc_pkg::RESP_SLVERR, 14'h0000});
    axw(4'h6, 32'h0);
    chk("bad write", last_b, 16'(lmc_pkg::RESP_SLVERR));
    // far node already holds actual position after its thermal stop
    chk("far node hold", b_target, 16'h1234);
    raw(8'h61, 32'h5678ABCD, 8'hB6);
    chk("bad checksum", b_target, 16'h1234);
    raw(8'hE1, 32'h5678ABCD, 8'hB7);
    chk("bad parity", b_target, 16'h1234);
    raw(8'h61, 32'h5678ABCD, 8'hB7);
    chk("good frame", b_target, 16'h5678);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("probe reset", emf_probe_active, 16'h0000);
    test_done();
  end
endmodule: lin_motor_command_decoder_tb
